// ===== src/hsem_map.svh
`ifndef HSEM_MAP_SVH
`define HSEM_MAP_SVH

// ==========================================================================
// Sizes of the semaphore pool
// ==========================================================================
`define HSEM_NUM_SEM      32
`define HSEM_NUM_MST      2
`define HSEM_SEM_IDX_W    5

// ==========================================================================
// Requester privilege field
// ==========================================================================
`define HSEM_PRIV_W       4
`define HSEM_PRIV_MAX     4'h1

// ==========================================================================
// Reset values of the semaphore state
// ==========================================================================
`define HSEM_OWNED_RST    1'b0
`define HSEM_OWNER_RST    1'b0
`define HSEM_PEND_RST     1'b0

`endif

// ===== src/hsem_pkg.sv
`include "hsem_map.svh"

package hsem_pkg;

  // ========================================================================
  // Request operations
  // ========================================================================
  typedef enum logic [1:0] {
    HSEM_OP_DIRECT   = 2'h0,
    HSEM_OP_INDIRECT = 2'h1,
    HSEM_OP_RELEASE  = 2'h2,
    HSEM_OP_QUERY    = 2'h3
  } hsem_op_e;

  // ========================================================================
  // Request, decoded command and answer
  // ========================================================================
  typedef struct packed {
    logic                         valid;
    hsem_op_e                     op;
    logic [`HSEM_SEM_IDX_W-1:0]   sem;
    logic [`HSEM_PRIV_W-1:0]      requester_privilege_number;
  } hsem_req_s;

  typedef struct packed {
    logic                         valid;
    logic                         refused;
    hsem_op_e                     op;
    logic [`HSEM_SEM_IDX_W-1:0]   sem;
    logic                         master;
  } hsem_cmd_s;

  typedef struct packed {
    logic                         valid;
    logic                         refused;
    logic                         granted;
    logic                         queued;
    logic                         fault;
    logic                         owned;
    logic                         owner;
  } hsem_rsp_s;

endpackage : hsem_pkg

// ===== src/hsem_gate.sv
`timescale 1ns/1ps

`include "hsem_map.svh"

// Privilege screen and command decode in front of the semaphore pool
module hsem_gate (
  input  hsem_pkg::hsem_req_s req_i,
  output hsem_pkg::hsem_cmd_s cmd_o
);

  // ========================================================================
  // Privilege check
  // ========================================================================
  function automatic logic priv_ok(input logic [`HSEM_PRIV_W-1:0] priv);
    priv_ok = (priv <= `HSEM_PRIV_MAX);
  endfunction : priv_ok

  // Privilege number selects the master; anything above 1 is refused
  always_comb begin
    cmd_o.valid   = req_i.valid;
    cmd_o.refused = !priv_ok(req_i.requester_privilege_number);
    cmd_o.op      = req_i.op;
    cmd_o.sem     = req_i.sem;
    cmd_o.master  = req_i.requester_privilege_number[0];
  end

endmodule : hsem_gate

// ===== src/hsem_arbiter.sv
`timescale 1ns/1ps

`include "hsem_map.svh"

// Function
// - Thirty-two semaphores, two masters, owner of each semaphore tracked.
// - Each acquire or release completes atomically; no interleaving.
// - Separate interrupt per core, pulsed when that core gains ownership through indirect access.
// - Only privilege numbers 0 and 1 are served; all others refused.
// - Direct access grants a free semaphore at once; if the other core holds it, reports not granted.
// - Indirect access queues; once free, semaphore goes to core with interrupt.
module hsem_arbiter #(
  parameter int NUM_SEM = `HSEM_NUM_SEM,
  parameter int NUM_MST = `HSEM_NUM_MST
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  input  wire hsem_pkg::hsem_req_s          req_i,
  output hsem_pkg::hsem_rsp_s               rsp_o,
  output logic [NUM_MST-1:0]                irq_o,
  output logic [`HSEM_SEM_IDX_W-1:0]        irq_sem_o,
  output logic [NUM_SEM-1:0]                sem_owned_o,
  output logic [NUM_SEM-1:0]                sem_owner_o
);

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  if (NUM_MST != 2) begin : g_bad_mst
    $error("hsem_arbiter serves exactly two masters");
  end
  if (NUM_SEM < 2 || NUM_SEM > (1 << `HSEM_SEM_IDX_W)) begin : g_bad_sem
    $error("hsem_arbiter semaphore count out of range");
  end

  localparam logic [`HSEM_SEM_IDX_W-1:0] SEM_LAST = `HSEM_SEM_IDX_W'(NUM_SEM - 1);

  // ========================================================================
  // Decode
  // ========================================================================
  hsem_pkg::hsem_cmd_s cmd;

  hsem_gate u_gate (
    .req_i (req_i),
    .cmd_o (cmd)
  );

  // ========================================================================
  // Semaphore state
  // ========================================================================
  logic [NUM_SEM-1:0]               owned;
  logic [NUM_SEM-1:0]               owner;
  logic [NUM_MST-1:0][NUM_SEM-1:0]  pend;
  logic [NUM_SEM-1:0]               next_owned;
  logic [NUM_SEM-1:0]               next_owner;
  logic [NUM_MST-1:0][NUM_SEM-1:0]  next_pend;
  hsem_pkg::hsem_rsp_s              rsp;
  hsem_pkg::hsem_rsp_s              next_rsp;
  logic [NUM_MST-1:0]               next_irq;
  logic [`HSEM_SEM_IDX_W-1:0]       next_irq_sem;
  logic                             sem_ok;

  assign sem_ok = (cmd.sem <= SEM_LAST);

  // One request per cycle, applied in one step, so a read-modify-write on a
  // semaphore can never be split by the other master. Only a non-owner can
  // wait on a semaphore, so at most one waiter exists and arrival order holds.
  always_comb begin
    logic m;
    logic o;
    m            = cmd.master;
    o            = ~cmd.master;
    next_owned   = owned;
    next_owner   = owner;
    next_pend    = pend;
    next_rsp     = '0;
    next_irq     = '0;
    next_irq_sem = irq_sem_o;
    if (cmd.valid) begin
      next_rsp.valid = 1'b1;
      if (cmd.refused || !sem_ok) begin
        next_rsp.refused = 1'b1;
      end else begin
        case (cmd.op)
          hsem_pkg::HSEM_OP_DIRECT: begin
            if (!owned[cmd.sem]) begin
              next_owned[cmd.sem] = 1'b1;
              next_owner[cmd.sem] = m;
              next_rsp.granted    = 1'b1;
            end else begin
              next_rsp.granted    = (owner[cmd.sem] == m);
            end
          end
          hsem_pkg::HSEM_OP_INDIRECT: begin
            if (!owned[cmd.sem]) begin
              next_owned[cmd.sem] = 1'b1;
              next_owner[cmd.sem] = m;
              next_rsp.granted    = 1'b1;
              next_irq[m]         = 1'b1;
              next_irq_sem        = cmd.sem;
            end else if (owner[cmd.sem] == m) begin
              next_rsp.granted    = 1'b1;
            end else begin
              next_pend[m][cmd.sem] = 1'b1;
              next_rsp.queued       = 1'b1;
            end
          end
          hsem_pkg::HSEM_OP_RELEASE: begin
            if (owned[cmd.sem] && owner[cmd.sem] == m) begin
              if (pend[o][cmd.sem]) begin
                next_owner[cmd.sem]   = o;
                next_pend[o][cmd.sem] = 1'b0;
                next_irq[o]           = 1'b1;
                next_irq_sem          = cmd.sem;
              end else begin
                next_owned[cmd.sem]   = 1'b0;
              end
            end else begin
              // A waiter withdraws its wait; ownership stays where it is
              next_pend[m][cmd.sem] = 1'b0;
              next_rsp.fault        = 1'b1;
            end
          end
          hsem_pkg::HSEM_OP_QUERY: begin
            next_rsp.granted = owned[cmd.sem] && (owner[cmd.sem] == m);
          end
          default: begin
            next_rsp.refused = 1'b1;
          end
        endcase
      end
      if (sem_ok) begin
        next_rsp.owned = next_owned[cmd.sem];
        next_rsp.owner = next_owner[cmd.sem];
      end
    end
  end

  // State and answer registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      owned     <= {NUM_SEM{`HSEM_OWNED_RST}};
      owner     <= {NUM_SEM{`HSEM_OWNER_RST}};
      pend      <= {(NUM_MST*NUM_SEM){`HSEM_PEND_RST}};
      rsp       <= '0;
      irq_o     <= '0;
      irq_sem_o <= '0;
    end else begin
      owned     <= next_owned;
      owner     <= next_owner;
      pend      <= next_pend;
      rsp       <= next_rsp;
      irq_o     <= next_irq;
      irq_sem_o <= next_irq_sem;
    end
  end

  // Outputs straight from flops
  assign rsp_o       = rsp;
  assign sem_owned_o = owned;
  assign sem_owner_o = owner;

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  logic good_req;
  assign good_req = cmd.valid && !cmd.refused && sem_ok;

  AST_PRIV_REFUSE: assert property (
    (cmd.valid && cmd.refused) |=> (rsp_o.valid && rsp_o.refused && !rsp_o.granted
                                    && $stable(owned) && $stable(owner) && $stable(pend)))
    else $error("Refused request changed state or was not refused");

  AST_DIRECT_FREE: assert property (
    (good_req && cmd.op == hsem_pkg::HSEM_OP_DIRECT && !owned[cmd.sem])
    |=> (rsp_o.granted && owned[$past(cmd.sem)] && owner[$past(cmd.sem)] == $past(cmd.master)))
    else $error("Direct access to free semaphore not granted");

  AST_DIRECT_BUSY: assert property (
    (good_req && cmd.op == hsem_pkg::HSEM_OP_DIRECT && owned[cmd.sem]
     && owner[cmd.sem] != cmd.master)
    |=> (!rsp_o.granted && !rsp_o.queued && $stable(owner) && $stable(pend)))
    else $error("Direct access to busy semaphore not refused cleanly");

  AST_INDIRECT_WAIT: assert property (
    (good_req && cmd.op == hsem_pkg::HSEM_OP_INDIRECT && owned[cmd.sem]
     && owner[cmd.sem] != cmd.master)
    |=> (rsp_o.queued && pend[$past(cmd.master)][$past(cmd.sem)] && irq_o == '0))
    else $error("Indirect request on busy semaphore not recorded");

  AST_HANDOFF: assert property (
    (good_req && cmd.op == hsem_pkg::HSEM_OP_RELEASE && owned[cmd.sem]
     && owner[cmd.sem] == cmd.master && pend[!cmd.master][cmd.sem])
    |=> (owned[$past(cmd.sem)] && owner[$past(cmd.sem)] != $past(cmd.master)
         && irq_o[!$past(cmd.master)] && irq_sem_o == $past(cmd.sem))
    ##1 (irq_o == '0 || $past(good_req)))
    else $error("Release did not hand semaphore to waiting core");

  AST_IRQ_CAUSE: assert property (
    (irq_o != '0) |-> ($past(good_req) && $onehot(irq_o) && owned[irq_sem_o]
                       && irq_o[owner[irq_sem_o]]))
    else $error("Interrupt without ownership by that core");

  AST_NONOWNER_RELEASE: assert property (
    (good_req && cmd.op == hsem_pkg::HSEM_OP_RELEASE && owned[cmd.sem]
     && owner[cmd.sem] != cmd.master)
    |=> (rsp_o.fault && $stable(owned) && $stable(owner)))
    else $error("Release by non-owner changed ownership");

  AST_FREE_CAUSE: assert property (
    (|($past(owned) & ~owned)) |-> ($past(good_req)
                                    && $past(cmd.op) == hsem_pkg::HSEM_OP_RELEASE))
    else $error("Semaphore freed without owner release");

  AST_ATOMIC: assert property (
    $countones(owned ^ $past(owned)) <= 1 && $countones(owner ^ $past(owner)) <= 1)
    else $error("More than one semaphore changed in one step");

  COV_DIRECT_GRANT: cover property (
    good_req && cmd.op == hsem_pkg::HSEM_OP_DIRECT ##1 rsp_o.granted);
  COV_WAIT_THEN_HANDOFF: cover property (
    rsp_o.queued ##[1:20] (irq_o != '0));
  COV_PRIV_REFUSE: cover property (
    cmd.valid && cmd.refused);
  COV_BOTH_IRQ: cover property (
    irq_o[0] ##[1:20] irq_o[1]);

endmodule : hsem_arbiter

// ===== verif/hsem_cores.sv
`timescale 1ns/1ps

// ==========================================================================
// Two requesting cores sharing one request port
// ==========================================================================
module hsem_cores (
  output hsem_pkg::hsem_req_s req_o
);
  // Nothing is requested before the bench asks for it
  initial begin
    req_o = '0;
  end

  // Present one request; software picks the semaphore freely, and a bridged
  // requester may arrive carrying any privilege number, forbidden ones included
  task automatic drive(input hsem_pkg::hsem_op_e op, input logic [4:0] sem,
                       input logic [3:0] priv);
    req_o.valid                      = 1'b1;
    req_o.op                         = op;
    req_o.sem                        = sem;
    req_o.requester_privilege_number = priv;
  endtask : drive

  // Released fields flip so a stale value is never mistaken for a live one
  task automatic idle();
    req_o.valid                      = 1'b0;
    req_o.op                         = hsem_pkg::hsem_op_e'(~req_o.op);
    req_o.sem                        = ~req_o.sem;
    req_o.requester_privilege_number = ~req_o.requester_privilege_number;
  endtask : idle
endmodule : hsem_cores

// ===== verif/hsem_arbiter_tb.sv
`timescale 1ns/1ps

module hsem_arbiter_tb;
  logic                core_clk_i;
  logic                resetn_i;
  hsem_pkg::hsem_req_s req;
  hsem_pkg::hsem_rsp_s rsp;
  hsem_pkg::hsem_rsp_s got;
  logic [1:0]          irq;
  logic [1:0]          got_irq;
  logic [4:0]          irq_sem;
  logic [31:0]         owned;
  logic [31:0]         owner;
  int                  err_total;
  int                  cmp_count;

  // ========================================================================
  // Clock, partner and design
  // ========================================================================
  initial core_clk_i = 1'b0;
  always #4 core_clk_i = ~core_clk_i;

  hsem_cores cores (.req_o(req));

  hsem_arbiter dut (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .req_i       (req),
    .rsp_o       (rsp),
    .irq_o       (irq),
    .irq_sem_o   (irq_sem),
    .sem_owned_o (owned),
    .sem_owner_o (owner)
  );

  // ========================================================================
  // Shared helpers
  // ========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Expected answer laid out as refused, granted, queued, fault, owned, owner
  task automatic chk_rsp(input logic [5:0] exp);
    chk("response", {25'h0, 1'b1, exp}, 32'(got));
  endtask : chk_rsp

  // One request; the answer stands for only the cycle after the taking edge,
  // so it is picked up at the falling edge inside that cycle
  task automatic xfer(input hsem_pkg::hsem_op_e op, input logic [4:0] sem,
                      input logic [3:0] priv);
    @(negedge core_clk_i) cores.drive(op, sem, priv);
    @(negedge core_clk_i);
    got     = rsp;
    got_irq = irq;
    cores.idle();
  endtask : xfer

  // ========================================================================
  // Scenarios
  // ========================================================================
  // Back-to-back direct grabs of one semaphore: the later one must lose
  task automatic t_direct();
    @(negedge core_clk_i) cores.drive(hsem_pkg::HSEM_OP_DIRECT, 5'h03, 4'h0);
    @(negedge core_clk_i);
    got = rsp;
    cores.drive(hsem_pkg::HSEM_OP_DIRECT, 5'h03, 4'h1);
    chk_rsp(6'b010010);
    @(negedge core_clk_i);
    got = rsp;
    cores.idle();
    chk_rsp(6'b000010);
    chk("owned3", 32'h1, 32'(owned[3]));
    chk("owner3", 32'h0, 32'(owner[3]));
    xfer(hsem_pkg::HSEM_OP_DIRECT, 5'h1f, 4'h1);
    chk_rsp(6'b010011);
    chk("owner31", 32'h1, 32'(owner[31]));
    $display("test direct done");
  endtask : t_direct

  // Waiter on a held semaphore gets it, with its own interrupt, on release
  task automatic t_indirect();
    xfer(hsem_pkg::HSEM_OP_INDIRECT, 5'h03, 4'h1);
    chk_rsp(6'b001010);
    chk("irq queued", 32'h0, 32'(got_irq));
    xfer(hsem_pkg::HSEM_OP_RELEASE, 5'h03, 4'h0);
    chk_rsp(6'b000011);
    chk("irq handover", 32'h2, 32'(got_irq));
    chk("irq sem", 32'h3, 32'(irq_sem));
    chk("owner3", 32'h1, 32'(owner[3]));
    $display("test indirect done");
  endtask : t_indirect

  // Release by the wrong core is a fault; the owner's release frees it
  task automatic t_release();
    xfer(hsem_pkg::HSEM_OP_RELEASE, 5'h03, 4'h0);
    chk_rsp(6'b000111);
    chk("owned3", 32'h1, 32'(owned[3]));
    xfer(hsem_pkg::HSEM_OP_RELEASE, 5'h03, 4'h1);
    chk("fault", 32'h0, 32'(got.fault));
    chk("owned3", 32'h0, 32'(owned[3]));
    xfer(hsem_pkg::HSEM_OP_INDIRECT, 5'h05, 4'h0);
    chk("granted", 32'h1, 32'(got.granted));
    chk("irq free", 32'h1, 32'(got_irq));
    chk("irq sem", 32'h5, 32'(irq_sem));
    $display("test release done");
  endtask : t_release

  // Every forbidden privilege number is refused and changes nothing
  task automatic t_priv();
    for (int p = 2; p < 16; p++) begin
      xfer(hsem_pkg::HSEM_OP_DIRECT, 5'h07, 4'(p));
      chk_rsp(6'b100000);
      chk("owned7", 32'h0, 32'(owned[7]));
    end
    $display("test privilege done");
  endtask : t_priv

  // Query tells only the owner it holds the semaphore; a repeat wait by the
  // owner is not a new acquisition, so it must neither queue nor interrupt
  task automatic t_query();
    xfer(hsem_pkg::HSEM_OP_QUERY, 5'h1f, 4'h1);
    chk_rsp(6'b010011);
    xfer(hsem_pkg::HSEM_OP_QUERY, 5'h1f, 4'h0);
    chk_rsp(6'b000011);
    xfer(hsem_pkg::HSEM_OP_INDIRECT, 5'h1f, 4'h1);
    chk("queued", 32'h0, 32'(got.queued));
    chk("irq repeat", 32'h0, 32'(got_irq));
    chk("owner31", 32'h1, 32'(owner[31]));
    $display("test query done");
  endtask : t_query

  // Reset in mid-run drops every ownership; the first request after it is served
  task automatic t_reset();
    @(negedge core_clk_i) resetn_i = 1'b0;
    @(negedge core_clk_i);
    chk("owned all", 32'h0, owned);
    chk("owner all", 32'h0, owner);
    chk("irq reset", 32'h0, 32'(irq));
    resetn_i = 1'b1;
    xfer(hsem_pkg::HSEM_OP_DIRECT, 5'h05, 4'h1);
    chk_rsp(6'b010011);
    chk("owner5", 32'h1, 32'(owner[5]));
    $display("test reset done");
  endtask : t_reset

  // ========================================================================
  // Run control
  // ========================================================================
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is about 63 cycles; this leaves ample margin
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    resetn_i  = 1'b0;
    repeat (10) @(negedge core_clk_i);
    resetn_i = 1'b1;
    t_direct();
    t_indirect();
    t_release();
    t_priv();
    t_query();
    t_reset();
    report_and_stop();
  end
endmodule : hsem_arbiter_tb
